// ==== rtl/code_conv.sv ====
/*
  Turns a contamination code given in tenths into its integer code and
  an interpolated count in units of 1/1024 particle per ml.
  Assumes codes of 0.0 to 29.9; larger inputs saturate at 29.9.
*/
`timescale 1ns/1ps
module code_conv
  import sched_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [CODE_W-1:0] in_tenths,
  output code_res_s res,
  output logic res_valid
);
  logic [CODE_W-1:0] code_c;
  logic [4:0] int_c;
  logic [3:0] frac_c;
  logic [COUNT_W-1:0] base_c;
  logic [COUNT_W-1:0] count_c;

  // Truncate, then interpolate linearly inside the doubling step
  always_comb begin
    code_c = (in_tenths > 9'h12B) ? 9'h12B : in_tenths;
    int_c = 5'(code_c / CODE_W'(TENTHS_PER_CODE));
    frac_c = 4'(code_c % CODE_W'(TENTHS_PER_CODE));
    base_c = COUNT_W'(COUNT_BASE) << int_c;
    count_c = base_c + COUNT_W'((base_c * COUNT_W'(frac_c))
      / COUNT_W'(TENTHS_PER_CODE));
  end

  // Result and its strobe are registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res <= '0;
      res_valid <= 1'b0;
    end else begin
      res_valid <= in_valid;
      if (in_valid) begin
        res <= '{code_int: int_c, tenths: frac_c, count: count_c};
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  trunc_code_a: assert property (in_valid |=>
    res.code_int * 10 + res.tenths == $past(code_c))
    else $error("integer code not truncated");
  double_step_a: assert property (in_valid && frac_c == 4'h0 |=>
    res.count == (COUNT_W'(COUNT_BASE) << res.code_int))
    else $error("integer code count not a doubling");
  conv_cov: cover property (in_valid && frac_c == 4'h8);
endmodule

// ==== rtl/sched_pkg.sv ====
/*
  Constants, types and timing figures shared by the thermal scheduler
  and its helpers. Assumes one 40 MHz system clock.
*/
package sched_pkg;
  localparam int unsigned CLOCK_HZ = 40_000_000;
  localparam int SEC_W = 16;
  localparam logic [SEC_W-1:0] DEF_SAMPLE_S = 16'h003C;
  localparam logic [SEC_W-1:0] DEF_HOLD_S = 16'h00F0;
  localparam logic [SEC_W-1:0] MAX_HOLD_MIN = 16'h03E7;
  localparam logic [SEC_W-1:0] SEC_PER_MIN = 16'h003C;
  localparam logic [SEC_W-1:0] MAX_HOLD_S = 16'hEA24;
  localparam logic [SEC_W-1:0] MIN_HOLD_RAW_S = 16'h0002;
  localparam logic [SEC_W-1:0] MIN_HOLD_TERM_S = 16'h000F;
  localparam logic signed [7:0] TEMP_B50_C = 8'sh3C;
  localparam logic signed [7:0] TEMP_B25_C = 8'sh46;
  localparam logic signed [7:0] TEMP_B10_C = 8'sh4B;
  localparam logic signed [7:0] TEMP_STOP_C = 8'sh50;
  localparam logic [4:0] MUL_B50 = 5'h01;
  localparam logic [4:0] MUL_B25 = 5'h03;
  localparam logic [4:0] MUL_B10 = 5'h09;
  localparam logic [3:0] TENTHS_PER_CODE = 4'hA;
  localparam logic [3:0] COUNT_BASE = 4'h5;
  localparam int CODE_W = 9;
  localparam int COUNT_W = 36;

  typedef enum logic [2:0] {
    BAND_NORMAL = 3'b000,
    BAND_HALF = 3'b001,
    BAND_QUARTER = 3'b010,
    BAND_TENTH = 3'b011,
    BAND_STOP = 3'b100
  } band_e;

  typedef struct packed {
    logic [SEC_W-1:0] sample_s;
    logic [SEC_W-1:0] hold_s;
  } sched_cfg_s;

  typedef struct packed {
    logic [4:0] code_int;
    logic [3:0] tenths;
    logic [COUNT_W-1:0] count;
  } code_res_s;
endpackage

// ==== rtl/sec_tick.sv ====
/*
  Divides the system clock down to a one-cycle pulse each second.
  Assumes a free running clock and an asynchronous active low reset.
*/
`timescale 1ns/1ps
module sec_tick #(
  parameter int unsigned CYCLES_PER_SEC = 40_000_000
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  initial begin
    if (CYCLES_PER_SEC < 2) begin
      $error("sec_tick needs at least two cycles per second");
    end
  end

  logic [31:0] cnt_q;

  // Wrap counter, tick on the last cycle of each second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0000_0000;
    end else if (cnt_q == 32'(CYCLES_PER_SEC - 1)) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  assign tick = (cnt_q == 32'(CYCLES_PER_SEC - 1));
endmodule

// ==== rtl/thermal_sched.sv ====
/*
  Sample and hold scheduler with thermal derating of the hold time.
  Assumes TEMP_C_IN is a settled signed Celsius value sampled on the
  clock; all inputs synchronous to CLOCK_IN.
*/
`timescale 1ns/1ps
module thermal_sched #(
  parameter int unsigned CYCLES_PER_SEC = sched_pkg::CLOCK_HZ
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  // Temperature and configuration
  input wire logic signed [7:0] TEMP_C_IN,
  input wire logic CFG_WR_IN,
  input wire sched_pkg::sched_cfg_s CFG_IN,
  input wire logic TERMINAL_MODE_IN,
  // Code conversion request
  input wire logic CODE_VALID_IN,
  input wire logic [sched_pkg::CODE_W-1:0] CODE_TENTHS_IN,
  // Scheduler state
  output logic SAMPLING_OUT,
  output logic DATA_READY_OUT,
  output logic [sched_pkg::SEC_W-1:0] SAMPLE_S_OUT,
  output logic [sched_pkg::SEC_W-1:0] HOLD_S_OUT,
  output sched_pkg::band_e BAND_OUT,
  // Code conversion result
  output sched_pkg::code_res_s CODE_RES_OUT,
  output logic CODE_RES_VALID_OUT
);
  import sched_pkg::*;

  initial begin
    if (CYCLES_PER_SEC < 2) begin
      $error("CYCLES_PER_SEC too small");
    end
  end

  typedef enum logic {
    ST_SAMPLE = 1'b0,
    ST_HOLD = 1'b1
  } state_e;

  // Most restrictive band that the temperature exceeds, or reaches for the stop band
  function automatic band_e band_of(input logic signed [7:0] t);
    if (t >= TEMP_STOP_C) begin
      band_of = BAND_STOP;
    end else if (t > TEMP_B10_C) begin
      band_of = BAND_TENTH;
    end else if (t > TEMP_B25_C) begin
      band_of = BAND_QUARTER;
    end else if (t > TEMP_B50_C) begin
      band_of = BAND_HALF;
    end else begin
      band_of = BAND_NORMAL;
    end
  endfunction

  // Sample multiple the hold must reach, saturated to the field
  function automatic logic [SEC_W-1:0] scaled(
    input logic [SEC_W-1:0] s,
    input logic [4:0] m
  );
    logic [SEC_W+4:0] p;
    p = (SEC_W+5)'(s) * (SEC_W+5)'(m);
    scaled = (p > (SEC_W+5)'(16'hFFFF)) ? 16'hFFFF : SEC_W'(p);
  endfunction

  // Hold for the next cycle from band, setting and output mode
  function automatic logic [SEC_W-1:0] next_hold(
    input sched_cfg_s c,
    input band_e b,
    input logic term
  );
    logic [SEC_W-1:0] req;
    logic [SEC_W-1:0] h;
    logic [SEC_W-1:0] mn;
    unique case (b)
      BAND_NORMAL: req = '0;
      BAND_HALF: req = scaled(c.sample_s, MUL_B50);
      BAND_QUARTER: req = scaled(c.sample_s, MUL_B25);
      BAND_TENTH: req = scaled(c.sample_s, MUL_B10);
      BAND_STOP: req = MAX_HOLD_S;
      default: req = MAX_HOLD_S;
    endcase
    if (b == BAND_STOP) begin
      h = MAX_HOLD_S;
    end else if (c.hold_s >= req) begin
      h = c.hold_s;
    end else begin
      h = req;
    end
    mn = term ? MIN_HOLD_TERM_S : MIN_HOLD_RAW_S;
    next_hold = (h < mn) ? mn : h;
  endfunction

  logic tick;
  state_e state_q;
  logic [SEC_W-1:0] sec_q;
  sched_cfg_s cfg_q;
  logic [SEC_W-1:0] sample_q;
  logic [SEC_W-1:0] hold_q;
  band_e band_q;
  logic ready_q;
  logic sample_end;
  logic cycle_end;
  band_e band_now;

  sec_tick #(
    .CYCLES_PER_SEC(CYCLES_PER_SEC)
  ) u_tick (
    .clk(CLOCK_IN),
    .rst_n(RST_N_IN),
    .tick(tick)
  );

  code_conv u_conv (
    .clk(CLOCK_IN),
    .rst_n(RST_N_IN),
    .in_valid(CODE_VALID_IN),
    .in_tenths(CODE_TENTHS_IN),
    .res(CODE_RES_OUT),
    .res_valid(CODE_RES_VALID_OUT)
  );

  // Phase ends on the tick that completes its last second
  assign sample_end = tick && (state_q == ST_SAMPLE)
    && (sec_q + 16'h0001 >= sample_q);
  assign cycle_end = tick && (state_q == ST_HOLD)
    && (sec_q + 16'h0001 >= hold_q);
  assign band_now = band_of(TEMP_C_IN);

  // Stored settings; a zero sample period is refused
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cfg_q <= '{sample_s: DEF_SAMPLE_S, hold_s: DEF_HOLD_S};
    end else if (CFG_WR_IN && CFG_IN.sample_s != '0) begin
      cfg_q <= CFG_IN;
    end
  end

  // Alternating sample and hold phases
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= ST_SAMPLE;
      sec_q <= '0;
    end else if (sample_end) begin
      state_q <= ST_HOLD;
      sec_q <= '0;
    end else if (cycle_end) begin
      state_q <= ST_SAMPLE;
      sec_q <= '0;
    end else if (tick) begin
      sec_q <= sec_q + 16'h0001;
    end
  end

  // Cycle-end evaluation: the only place timing is re-derived
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sample_q <= DEF_SAMPLE_S;
      hold_q <= DEF_HOLD_S;
      band_q <= BAND_NORMAL;
    end else if (cycle_end) begin
      sample_q <= cfg_q.sample_s;
      hold_q <= next_hold(cfg_q, band_now, TERMINAL_MODE_IN);
      band_q <= band_now;
    end
  end

  // One data output per cycle, when sampling completes
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= sample_end;
    end
  end

  assign SAMPLING_OUT = (state_q == ST_SAMPLE);
  assign DATA_READY_OUT = ready_q;
  assign SAMPLE_S_OUT = sample_q;
  assign HOLD_S_OUT = hold_q;
  assign BAND_OUT = band_q;

  // Checks
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);

  logic first_q;
  logic [SEC_W+4:0] s9;
  logic [SEC_W+4:0] s3;

  // Marks the cycle that started at reset
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      first_q <= 1'b1;
    end else if (cycle_end) begin
      first_q <= 1'b0;
    end
  end

  assign s9 = (SEC_W+5)'(cfg_q.sample_s) * (SEC_W+5)'(MUL_B10);
  assign s3 = (SEC_W+5)'(cfg_q.sample_s) * (SEC_W+5)'(MUL_B25);

  reset_default_a: assert property (first_q |->
    hold_q == 16'h00F0 && sample_q == 16'h003C)
    else $error("reset timing not one and four minutes");
  ready_pulse_a: assert property (sample_end |=>
    DATA_READY_OUT && state_q == ST_HOLD && sec_q == '0)
    else $error("data output not at end of sample");
  half_duty_a: assert property (cycle_end && band_now == BAND_HALF
    |=> hold_q >= sample_q)
    else $error("duty above half");
  quarter_duty_a: assert property (cycle_end
    && band_now == BAND_QUARTER && s3 < 20'h10000
    |=> 20'(hold_q) >= $past(s3))
    else $error("duty above quarter");
  tenth_duty_a: assert property (cycle_end
    && band_now == BAND_TENTH && s9 < 20'h10000
    |=> 20'(hold_q) >= $past(s9))
    else $error("duty above tenth");
  stop_hold_a: assert property (cycle_end
    && TEMP_C_IN >= 8'sh50 |=> hold_q == 16'hEA24 && band_q == BAND_STOP)
    else $error("stop hold not 999 minutes");
  sample_fixed_a: assert property (!cycle_end |=>
    $stable(sample_q))
    else $error("sample period changed outside cycle end");
  hold_steady_a: assert property (state_q == ST_HOLD ##1
    state_q == ST_HOLD |-> $stable(hold_q) && $stable(band_q))
    else $error("hold altered during hold");
  keep_setting_a: assert property (cycle_end
    && band_now == BAND_NORMAL && cfg_q.hold_s >= 16'h000F
    |=> hold_q == $past(cfg_q.hold_s))
    else $error("normal band changed hold");
  min_hold_a: assert property (cycle_end && TERMINAL_MODE_IN
    |=> hold_q >= 16'h000F)
    else $error("terminal hold below minimum");

  stop_cov: cover property (cycle_end && band_now == BAND_STOP);
  half_cov: cover property (cycle_end && band_now == BAND_HALF);
  ready_cov: cover property (DATA_READY_OUT ##[1:400] cycle_end);
endmodule

// ==== test/sensor_model.sv ====
/*
  Temperature sensor and laser front end beside the scheduler.
  Assumes the bench sets the wanted temperature on the shared clock.
*/
`timescale 1ns/1ps
module sensor_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Wanted temperature and scheduler strobe
  input wire logic signed [7:0] target_in,
  input wire logic ready_in,
  // Sensor reading and readings taken
  output logic signed [7:0] temp_out,
  output logic [15:0] reads_out
);
  // Sensor settles on a new value one clock later
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      temp_out <= 8'sh14;
    end else begin
      temp_out <= target_in;
    end
  end
  // Front end tally of readings; power cycling clears it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reads_out <= 16'h0000;
    end else if (ready_in) begin
      reads_out <= reads_out + 16'h0001;
    end
  end
endmodule

// ==== test/test_thermal_sched.sv ====
/*
  Self-checking bench for the thermal scheduler and code converter.
  Assumes the seconds divider is shortened to 4 clocks.
*/
`timescale 1ns/1ps
module test_thermal_sched;
  import sched_pkg::*;
  localparam int CPS = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic signed [7:0] target = 8'sh14;
  logic signed [7:0] temp;
  logic cfg_wr = 1'b0;
  sched_cfg_s cfg = '0;
  logic term = 1'b0;
  logic code_v = 1'b0;
  logic [CODE_W-1:0] code_t = '0;
  logic sampling, ready, res_v;
  logic [SEC_W-1:0] samp_s, hold_s;
  band_e band;
  code_res_s res;
  logic [15:0] reads;
  int err_total = 0;
  int total_checks = 0;
  int c;
  // Clock at 40 MHz
  always #12.5 clk = ~clk;
  thermal_sched #(.CYCLES_PER_SEC(CPS)) uut (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .TEMP_C_IN(temp),
    .CFG_WR_IN(cfg_wr), .CFG_IN(cfg), .TERMINAL_MODE_IN(term),
    .CODE_VALID_IN(code_v), .CODE_TENTHS_IN(code_t),
    .SAMPLING_OUT(sampling), .DATA_READY_OUT(ready),
    .SAMPLE_S_OUT(samp_s), .HOLD_S_OUT(hold_s), .BAND_OUT(band),
    .CODE_RES_OUT(res), .CODE_RES_VALID_OUT(res_v));
  sensor_model partner (.clk_in(clk), .rst_n_in(rst_n),
    .target_in(target), .ready_in(ready), .temp_out(temp),
    .reads_out(reads));
  // Comparison and report
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Inputs move 1 ns after the rising edge
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Bounded wait for the sampling flag to reach a level
  task automatic wait_lvl(input logic lvl, output int n);
    n = 0;
    while (sampling !== lvl && n < 20000) begin
      step(1);
      n++;
    end
    if (n >= 20000) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic cycle_end();
    wait_lvl(1'b0, c);
    wait_lvl(1'b1, c);
  endtask
  // Times one whole cycle from a cycle end: sample, ready, hold
  task automatic measure(input int smp, input int hld);
    logic [15:0] r0;
    r0 = reads;
    wait_lvl(1'b0, c);
    chk(c, smp * CPS);
    chk(ready, 1'b1);
    step(1);
    chk(ready, 1'b0);
    step(1);
    chk(ready, 1'b0);
    wait_lvl(1'b1, c);
    chk(c + 2, hld * CPS);
    chk(reads, r0 + 16'h0001);
  endtask
  task automatic set_cfg(input logic [15:0] s, input logic [15:0] h);
    cfg = {s, h};
    cfg_wr = 1'b1;
    step(1);
    cfg_wr = 1'b0;
  endtask
  // Count is 5*2^n per code, tenths spaced linearly
  function automatic code_res_s exp_code(input int v);
    code_res_s r;
    logic [63:0] base;
    if (v > 299) v = 299;
    base = 64'd5 << (v / 10);
    r.code_int = 5'(v / 10);
    r.tenths = 4'(v % 10);
    r.count = COUNT_W'(base + base * (v % 10) / 10);
    return r;
  endfunction
  logic signed [7:0] tt [7] = '{8'sh3D, 8'sh47, 8'sh4C, 8'sh3C,
    8'sh14, 8'sh14, 8'sh4C};
  logic [6:0] tm = 7'b0010000;
  logic [15:0] ch [7] = '{16'h0002, 16'h0002, 16'h0002, 16'h0002,
    16'h0002, 16'h0001, 16'h00C8};
  band_e eb [7] = '{BAND_HALF, BAND_QUARTER, BAND_TENTH, BAND_NORMAL,
    BAND_NORMAL, BAND_NORMAL, BAND_TENTH};
  logic [15:0] eh [7] = '{16'h000A, 16'h001E, 16'h005A, 16'h0002,
    16'h000F, 16'h0002, 16'h00C8};
  int cv [5] = '{72, 78, 10, 299, 305};
  // Main sequence
  initial begin
    step(4);
    rst_n = 1'b1;
    chk({sampling, samp_s, hold_s, band}, {1'b1, DEF_SAMPLE_S,
      DEF_HOLD_S, BAND_NORMAL});
    target = 8'sh48;
    cycle_end();
    chk({band, samp_s, hold_s}, {BAND_QUARTER, DEF_SAMPLE_S,
      DEF_HOLD_S});
    measure(60, 240);
    set_cfg(16'h000A, 16'h0002);
    set_cfg(16'h0000, 16'h0005);
    target = 8'sh14;
    cycle_end();
    chk({band, samp_s, hold_s}, {BAND_NORMAL, 16'h000A,
      16'h0002});
    for (int i = 0; i < 7; i++) begin
      target = tt[i];
      term = tm[i];
      set_cfg(16'h000A, ch[i]);
      cycle_end();
      chk({band, samp_s, hold_s}, {eb[i], 16'h000A, eh[i]});
    end
    measure(10, 200);
    target = 8'sh55;
    step(8);
    target = 8'sh14;
    cycle_end();
    chk(band, BAND_NORMAL);
    target = 8'sh50;
    cycle_end();
    chk({band, samp_s, hold_s}, {BAND_STOP, 16'h000A,
      MAX_HOLD_S});
    target = 8'sh14;
    wait_lvl(1'b0, c);
    step(2000);
    chk({sampling, hold_s}, {1'b0, MAX_HOLD_S});
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    chk({sampling, samp_s, hold_s, band, reads}, {1'b1, DEF_SAMPLE_S,
      DEF_HOLD_S, BAND_NORMAL, 16'h0000});
    for (int i = 0; i < 5; i++) begin
      code_v = 1'b1;
      code_t = CODE_W'(cv[i]);
      step(1);
      chk({res_v, res}, {1'b1, exp_code(cv[i])});
    end
    code_v = 1'b0;
    step(1);
    chk(res_v, 1'b0);
    print_verdict();
  end
endmodule
